/* design/rcaw_pkg.sv */
// Purpose: shared constants and types for the remote control arbiter and watchdog
// Assumes: 40 MHz system clock, APB register access with 32-bit data
// Notes:   register offsets are byte addresses
package rcaw_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned FAN_DELAY_MS  = 500;
	localparam int unsigned PWR_DELAY_MS  = 3000;
	localparam int unsigned WDT_TICK_US   = 1000;
	localparam int unsigned FAN_DELAY_CYC = CLK_HZ / 1000 * FAN_DELAY_MS;
	localparam int unsigned PWR_DELAY_CYC = CLK_HZ / 1000 * PWR_DELAY_MS;
	localparam int unsigned WDT_TICK_CYC  = CLK_HZ / 1000000 * WDT_TICK_US;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATE  = 12'h004;
	localparam logic [11:0] OFS_WDTO   = 12'h008;
	localparam logic [11:0] OFS_SETVAL = 12'h00C;
	localparam logic [11:0] OFS_SAVED  = 12'h010;
	localparam logic [11:0] OFS_IRQST  = 12'h014;
	localparam logic [11:0] OFS_IRQEN  = 12'h018;
	localparam logic [11:0] OFS_IRQCLR = 12'h01C;

	// ctrl fields
	localparam int CTRL_WDT_EN      = 0;
	localparam int CTRL_AFTER_ON    = 1;
	localparam int CTRL_RESTORE     = 2;
	localparam int CTRL_IS_MASTER   = 3;
	localparam int CTRL_ALARM_CLR   = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] WDTO_RST = 32'h0000_03E8;

	// interrupt event bits
	localparam int IRQ_WDT      = 0;
	localparam int IRQ_LINK     = 1;
	localparam int IRQ_REFUSE   = 2;
	localparam int IRQ_PFAIL    = 3;
	localparam int IRQ_W        = 4;

	// ****************************************
	// control owner and power sequence
	// ****************************************
	typedef enum logic [2:0] {
		OWN_LOCAL  = 3'b000,
		OWN_FRONT  = 3'b001,
		OWN_REAR   = 3'b010,
		OWN_MASTER = 3'b011
	} rcaw_owner_e;

	typedef enum logic [1:0] {
		PD_RUN  = 2'b00,
		PD_FANS = 2'b01,
		PD_PWR  = 2'b10,
		PD_OFF  = 2'b11
	} rcaw_pd_e;

	// one message event from a command port
	typedef struct packed {
		logic msg;       // any message received
		logic rem_req;   // request to enter remote
		logic rem_exit;  // request to leave remote
		logic set_cmd;   // write of set values or protections
		logic out_on;    // output on command
		logic out_off;   // output off command
		logic sub_ok;    // command is in the reduced front subset
		logic scpi;      // framing is scpi (else modbus rtu)
	} rcaw_cmd_s;

	typedef struct packed {
		logic accept;
		logic error;
	} rcaw_rsp_s;

endpackage

/* design/rcaw_top.sv */
// Purpose: arbitrates control of the output stage and supervises the remote link
// Assumes: command ports deliver decoded one-cycle events on mclk_in
// Notes:   pins pass two flip-flops before use
`timescale 1ns/10ps
`default_nettype none
module rcaw_top (
	input  wire logic                mclk_in,
	input  wire logic                nrst_in,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [11:0]         paddr_in,
	input  wire logic [31:0]         pwdata_in,
	output logic      [31:0]         prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out,
	input  wire logic                button_in,
	input  wire logic                mains_lost_in,
	input  wire logic                link_ok_in,
	input  wire logic                eth_timeout_in,
	input  wire rcaw_pkg::rcaw_cmd_s front_cmd_in,
	input  wire rcaw_pkg::rcaw_cmd_s rear_cmd_in,
	input  wire logic                ms_init_in,
	input  wire logic                dev_alarm_in,
	output rcaw_pkg::rcaw_rsp_s      front_rsp_out,
	output rcaw_pkg::rcaw_rsp_s      rear_rsp_out,
	output logic                     ms_init_ack_out,
	output logic                     output_on_out,
	output logic                     fans_on_out,
	output logic                     power_hold_out,
	output logic                     save_out,
	output logic                     power_fail_alarm_out,
	output logic                     link_protection_alarm_out,
	output logic                     error_led_out,
	output logic                     irq_out
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	logic       btn_prev_ff;
	always_ff @(posedge mclk_in) begin
		meta_ff <= {button_in, mains_lost_in, link_ok_in, eth_timeout_in};
		sync_ff <= meta_ff;
	end
	wire logic btn_s     = sync_ff[3];
	wire logic mains_s   = sync_ff[2];
	wire logic link_ok_s = sync_ff[1];
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			btn_prev_ff <= 1'b0;
		end else begin
			btn_prev_ff <= btn_s;
		end
	end
	wire logic btn_press = btn_s & ~btn_prev_ff;
	// ****************************************
	// registers and state
	// ****************************************
	logic [31:0]           ctrl_ff;
	logic [31:0]           wdto_ff;
	logic [31:0]           setval_ff;
	logic [31:0]           saved_set_ff;
	logic                  saved_out_ff;
	logic [rcaw_pkg::IRQ_W-1:0] irq_st_ff;
	logic [rcaw_pkg::IRQ_W-1:0] irq_en_ff;
	rcaw_pkg::rcaw_owner_e owner_ff;
	rcaw_pkg::rcaw_pd_e    pd_ff;
	logic [31:0]           pd_cnt_ff;
	logic                  out_ff;
	logic                  restored_ff;
	logic                  link_alarm_ff;
	logic                  dev_alarm_ff;
	logic                  pf_ff;
	logic [31:0]           wdt_cur_ff;
	logic [31:0]           wdt_cnt_ff;
	logic [31:0]           tick_ff;
	logic                  wdt_exp;
	wire logic apb_wr = psel_in & penable_in & pwrite_in;
	wire logic apb_rd = psel_in & penable_in & ~pwrite_in;
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == rcaw_pkg::OFS_CTRL) || (a == rcaw_pkg::OFS_STATE) ||
			(a == rcaw_pkg::OFS_WDTO) || (a == rcaw_pkg::OFS_SETVAL) ||
			(a == rcaw_pkg::OFS_SAVED) || (a == rcaw_pkg::OFS_IRQST) ||
			(a == rcaw_pkg::OFS_IRQEN) || (a == rcaw_pkg::OFS_IRQCLR);
	endfunction
	wire logic powering_down = (pd_ff != rcaw_pkg::PD_RUN);
	wire logic is_master     = ctrl_ff[rcaw_pkg::CTRL_IS_MASTER];
	wire logic usb_remote    = (owner_ff == rcaw_pkg::OWN_FRONT) || (owner_ff == rcaw_pkg::OWN_REAR);
	wire logic slave_remote  = (owner_ff == rcaw_pkg::OWN_MASTER);
	// ****************************************
	// request arbitration
	// ****************************************
	logic front_rem_ok;
	logic rear_rem_ok;
	logic front_err;
	logic rear_err;
	logic front_set_ok;
	logic ms_ok;
	always_comb begin
		rear_rem_ok  = rear_cmd_in.rem_req & ~slave_remote & (owner_ff != rcaw_pkg::OWN_FRONT);
		front_rem_ok = front_cmd_in.rem_req & front_cmd_in.sub_ok & ~slave_remote &
			(owner_ff != rcaw_pkg::OWN_REAR) & ~rear_rem_ok;
		front_set_ok = front_cmd_in.set_cmd & front_cmd_in.sub_ok &
			((owner_ff == rcaw_pkg::OWN_LOCAL) || (owner_ff == rcaw_pkg::OWN_FRONT));
		// no slave init under usb remote
		ms_ok        = ms_init_in & ~usb_remote;
		front_err    = (front_cmd_in.rem_req & ~front_rem_ok) |
			(front_cmd_in.set_cmd & ~front_set_ok) |
			(front_cmd_in.msg & ~front_cmd_in.sub_ok);
		rear_err     = (rear_cmd_in.rem_req & ~rear_rem_ok) |
			(rear_cmd_in.set_cmd & (owner_ff != rcaw_pkg::OWN_REAR) &
			(owner_ff != rcaw_pkg::OWN_LOCAL));
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			front_rsp_out   <= '0;
			rear_rsp_out    <= '0;
			ms_init_ack_out <= 1'b0;
		end else begin
			front_rsp_out.accept <= front_cmd_in.msg & ~front_err;
			front_rsp_out.error  <= front_err;
			rear_rsp_out.accept  <= rear_cmd_in.msg & ~rear_err;
			rear_rsp_out.error   <= rear_err;
			ms_init_ack_out      <= ms_ok;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			owner_ff <= rcaw_pkg::OWN_LOCAL;
		end else if (powering_down) begin
			owner_ff <= rcaw_pkg::OWN_LOCAL;
		end else if (wdt_exp) begin
			owner_ff <= rcaw_pkg::OWN_LOCAL;
		end else if (ms_ok) begin
			owner_ff <= rcaw_pkg::OWN_MASTER;
		end else if (rear_rem_ok) begin
			owner_ff <= rcaw_pkg::OWN_REAR;
		end else if (front_rem_ok) begin
			owner_ff <= rcaw_pkg::OWN_FRONT;
		end else if ((owner_ff == rcaw_pkg::OWN_FRONT && front_cmd_in.rem_exit) ||
			(owner_ff == rcaw_pkg::OWN_REAR && rear_cmd_in.rem_exit)) begin
			owner_ff <= rcaw_pkg::OWN_LOCAL;
		end
	end
	// ****************************************
	// output stage
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			out_ff      <= 1'b0;
			restored_ff <= 1'b0;
		end else if (powering_down || mains_s) begin
			out_ff <= 1'b0;
		end else if (!restored_ff) begin
			restored_ff <= 1'b1;
			out_ff      <= ctrl_ff[rcaw_pkg::CTRL_RESTORE] & saved_out_ff;
		end else if (wdt_exp) begin
			out_ff <= out_ff & ctrl_ff[rcaw_pkg::CTRL_AFTER_ON];
		end else if (link_alarm_ff) begin
			out_ff <= 1'b0;
		end else if (btn_press && !slave_remote && !usb_remote) begin
			out_ff <= ~out_ff;
		end else if (owner_ff == rcaw_pkg::OWN_REAR && (rear_cmd_in.out_on ||
			rear_cmd_in.out_off)) begin
			out_ff <= rear_cmd_in.out_on;
		end else if (front_set_ok && (front_cmd_in.out_on || front_cmd_in.out_off)) begin
			out_ff <= front_cmd_in.out_on;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			setval_ff <= 32'h0000_0000;
		end else if (apb_wr && paddr_in == rcaw_pkg::OFS_SETVAL) begin
			setval_ff <= pwdata_in;
		end
	end
	// ****************************************
	// power-down sequence
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			pd_ff     <= rcaw_pkg::PD_RUN;
			pd_cnt_ff <= 32'h0000_0000;
		end else begin
			case (pd_ff)
				rcaw_pkg::PD_RUN: begin
					if (mains_s) begin
						pd_ff     <= rcaw_pkg::PD_FANS;
						pd_cnt_ff <= 32'h0000_0000;
					end
				end
				rcaw_pkg::PD_FANS: begin
					if (pd_cnt_ff == rcaw_pkg::FAN_DELAY_CYC - 1) begin
						pd_ff     <= rcaw_pkg::PD_PWR;
						pd_cnt_ff <= 32'h0000_0000;
					end else begin
						pd_cnt_ff <= pd_cnt_ff + 32'h0000_0001;
					end
				end
				rcaw_pkg::PD_PWR: begin
					if (pd_cnt_ff == rcaw_pkg::PWR_DELAY_CYC - 1) begin
						pd_ff <= rcaw_pkg::PD_OFF;
					end else begin
						pd_cnt_ff <= pd_cnt_ff + 32'h0000_0001;
					end
				end
				default: begin
					pd_ff <= rcaw_pkg::PD_OFF;
				end
			endcase
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			saved_out_ff <= 1'b0;
			saved_set_ff <= 32'h0000_0000;
			save_out     <= 1'b0;
		end else begin
			save_out <= 1'b0;
			if (pd_ff == rcaw_pkg::PD_RUN && mains_s) begin
				saved_out_ff <= out_ff;
				saved_set_ff <= setval_ff;
				save_out     <= 1'b1;
			end
		end
	end
	// ****************************************
	// alarms
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			pf_ff         <= 1'b0;
			link_alarm_ff <= 1'b0;
			dev_alarm_ff  <= 1'b0;
		end else begin
			pf_ff <= powering_down | mains_s;
			if (slave_remote && !link_ok_s) begin
				link_alarm_ff <= 1'b1;
			end else if (btn_press || (apb_wr && paddr_in == rcaw_pkg::OFS_CTRL &&
				pwdata_in[rcaw_pkg::CTRL_ALARM_CLR])) begin
				link_alarm_ff <= 1'b0;
			end
			if (dev_alarm_in) begin
				dev_alarm_ff <= 1'b1;
			end else if (btn_press) begin
				dev_alarm_ff <= 1'b0;
			end
		end
	end
	// ****************************************
	// communication watchdog
	// ****************************************
	logic rx_msg;
	logic wdt_run;
	always_comb begin
		rx_msg = 1'b0;
		case (owner_ff)
			rcaw_pkg::OWN_FRONT: rx_msg = front_cmd_in.msg;
			rcaw_pkg::OWN_REAR:  rx_msg = rear_cmd_in.msg;
			default:             rx_msg = 1'b0;
		endcase
		wdt_run = ctrl_ff[rcaw_pkg::CTRL_WDT_EN] & usb_remote & ~powering_down;
		wdt_exp = wdt_run && (wdt_cnt_ff >= wdt_cur_ff) && !rx_msg &&
			(tick_ff == rcaw_pkg::WDT_TICK_CYC - 1);
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			tick_ff    <= 32'h0000_0000;
			wdt_cnt_ff <= 32'h0000_0000;
			wdt_cur_ff <= rcaw_pkg::WDTO_RST;
		end else if (!wdt_run) begin
			tick_ff    <= 32'h0000_0000;
			wdt_cnt_ff <= 32'h0000_0000;
			wdt_cur_ff <= wdto_ff;
		end else if (rx_msg) begin
			tick_ff    <= 32'h0000_0000;
			wdt_cnt_ff <= 32'h0000_0000;
		end else if (tick_ff == rcaw_pkg::WDT_TICK_CYC - 1) begin
			tick_ff <= 32'h0000_0000;
			if (wdt_cnt_ff >= wdt_cur_ff) begin
				wdt_cnt_ff <= 32'h0000_0000;
				wdt_cur_ff <= wdto_ff;
			end else begin
				wdt_cnt_ff <= wdt_cnt_ff + 32'h0000_0001;
			end
		end else begin
			tick_ff <= tick_ff + 32'h0000_0001;
		end
	end
	// ****************************************
	// apb slave and interrupts
	// ****************************************
	wire logic [rcaw_pkg::IRQ_W-1:0] irq_ev = {save_out,
		front_cmd_in.rem_req & ~front_rem_ok | rear_cmd_in.rem_req & ~rear_rem_ok,
		slave_remote & ~link_ok_s & ~link_alarm_ff, wdt_exp};
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			ctrl_ff   <= rcaw_pkg::CTRL_RST;
			wdto_ff   <= rcaw_pkg::WDTO_RST;
			irq_en_ff <= '0;
			irq_st_ff <= '0;
		end else begin
			if (apb_wr && paddr_in == rcaw_pkg::OFS_CTRL) begin
				ctrl_ff <= pwdata_in & ~(32'h0000_0001 << rcaw_pkg::CTRL_ALARM_CLR);
			end else if (apb_wr && paddr_in == rcaw_pkg::OFS_WDTO) begin
				wdto_ff <= pwdata_in;
			end else if (apb_wr && paddr_in == rcaw_pkg::OFS_IRQEN) begin
				irq_en_ff <= pwdata_in[rcaw_pkg::IRQ_W-1:0];
			end
			// set wins over clear
			if (apb_wr && paddr_in == rcaw_pkg::OFS_IRQCLR) begin
				irq_st_ff <= (irq_st_ff & ~pwdata_in[rcaw_pkg::IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_st_ff <= irq_st_ff | irq_ev;
			end
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			if (paddr_in == rcaw_pkg::OFS_CTRL) begin
				prdata_out <= ctrl_ff;
			end else if (paddr_in == rcaw_pkg::OFS_STATE) begin
				prdata_out <= {23'h00_0000, pd_ff, owner_ff, dev_alarm_ff, link_alarm_ff, pf_ff, out_ff};
			end else if (paddr_in == rcaw_pkg::OFS_WDTO) begin
				prdata_out <= wdto_ff;
			end else if (paddr_in == rcaw_pkg::OFS_SETVAL) begin
				prdata_out <= setval_ff;
			end else if (paddr_in == rcaw_pkg::OFS_SAVED) begin
				prdata_out <= {saved_out_ff, saved_set_ff[30:0]};
			end else if (paddr_in == rcaw_pkg::OFS_IRQST) begin
				prdata_out <= {28'h000_0000, irq_st_ff};
			end else if (paddr_in == rcaw_pkg::OFS_IRQEN) begin
				prdata_out <= {28'h000_0000, irq_en_ff};
			end else begin
				prdata_out <= 32'h0000_0000;
			end
		end
	end
	assign pready_out  = 1'b1;
	assign pslverr_out = (apb_wr | apb_rd) & ~is_mapped(paddr_in);
	assign irq_out     = |(irq_st_ff & irq_en_ff);
	// ****************************************
	// pin outputs
	// ****************************************
	assign output_on_out             = out_ff;
	assign fans_on_out               = (pd_ff == rcaw_pkg::PD_RUN) || (pd_ff == rcaw_pkg::PD_FANS);
	assign power_hold_out            = (pd_ff != rcaw_pkg::PD_OFF);
	assign power_fail_alarm_out      = pf_ff;
	assign link_protection_alarm_out = link_alarm_ff;
	assign error_led_out             = pf_ff | link_alarm_ff | dev_alarm_ff;
	wire logic unused_ok = is_master ^ sync_ff[0] ^ front_cmd_in.scpi ^ rear_cmd_in.scpi ^
		rear_cmd_in.sub_ok;
endmodule
`default_nettype wire

/* test/rcaw_props.sv */
// Purpose: port assertions for rcaw_top
// Assumes: one clock domain, synchronous active-low reset
// Notes:   attached by the bind below the module
`timescale 1ns/10ps
`default_nettype none
module rcaw_props (
	input wire logic                mclk_in,
	input wire logic                nrst_in,
	input wire logic                mains_lost_in,
	input wire logic                link_ok_in,
	input wire rcaw_pkg::rcaw_cmd_s front_cmd_in,
	input wire rcaw_pkg::rcaw_cmd_s rear_cmd_in,
	input wire rcaw_pkg::rcaw_rsp_s front_rsp_out,
	input wire rcaw_pkg::rcaw_rsp_s rear_rsp_out,
	input wire logic                output_on_out,
	input wire logic                save_out,
	input wire logic                power_fail_alarm_out,
	input wire logic                link_protection_alarm_out,
	input wire logic                error_led_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// ****************************************
	// power-down, command answers and alarms
	// ****************************************
	sequence s_mains_drop;
		$rose(mains_lost_in);
	endsequence
	sequence s_front_read;
		front_cmd_in.msg && front_cmd_in.sub_ok && !front_cmd_in.rem_req && !front_cmd_in.set_cmd;
	endsequence
	a_pd_save: assert property (s_mains_drop |-> ##[1:6] save_out)
		else $error("no save pulse after mains loss");
	a_pd_alarm: assert property (save_out |-> ##[0:2] power_fail_alarm_out)
		else $error("power fail alarm missing");
	a_pd_out_off: assert property ($rose(power_fail_alarm_out) |-> ##[0:1] (!output_on_out)[*4])
		else $error("output not off at power-down");
	a_front_answer: assert property (front_cmd_in.msg |=> front_rsp_out.accept != front_rsp_out.error)
		else $error("front answer not exactly one of accept or error");
	a_front_read: assert property (s_front_read |=> front_rsp_out.accept)
		else $error("front read refused");
	a_rear_read: assert property (rear_cmd_in.msg && !rear_cmd_in.rem_req && !rear_cmd_in.set_cmd
		&& !rear_cmd_in.out_on |=> rear_rsp_out.accept)
		else $error("rear read refused");
	a_subset_err: assert property (front_cmd_in.msg && !front_cmd_in.sub_ok |=> front_rsp_out.error)
		else $error("front command outside subset accepted");
	a_link_fault: assert property ($fell(link_ok_in) |-> ##[2:5] link_protection_alarm_out)
		else $error("link fault not flagged");
	a_led_alarm: assert property (power_fail_alarm_out || link_protection_alarm_out |-> ##[0:1] error_led_out)
		else $error("error indicator dark during alarm");
endmodule
bind rcaw_top rcaw_props rcaw_props_inst (.mclk_in, .nrst_in, .mains_lost_in, .link_ok_in,
	.front_cmd_in, .rear_cmd_in, .front_rsp_out, .rear_rsp_out, .output_on_out, .save_out,
	.power_fail_alarm_out, .link_protection_alarm_out, .error_led_out);
`default_nettype wire

/* test/rcaw_host_model.sv */
// Purpose: host and master unit sending message events to the command ports
// Assumes: one-cycle message pulses, answer one cycle later
// Notes:   gap argument adds idle cycles before each message is sent
`timescale 1ns/10ps
`default_nettype none
module rcaw_host_model (
	input  wire logic                mclk_in,
	input  wire rcaw_pkg::rcaw_rsp_s front_rsp_in,
	input  wire rcaw_pkg::rcaw_rsp_s rear_rsp_in,
	input  wire logic                ms_init_ack_in,
	output var rcaw_pkg::rcaw_cmd_s  front_cmd_out,
	output var rcaw_pkg::rcaw_cmd_s  rear_cmd_out,
	output var logic                 ms_init_out
);
	initial begin
		front_cmd_out = '0;
		rear_cmd_out = '0;
		ms_init_out = 1'b0;
	end
	task send(input bit rear, input rcaw_pkg::rcaw_cmd_s c, input int gap,
		output rcaw_pkg::rcaw_rsp_s r);
		repeat (gap + 1) @(posedge mclk_in);
		if (rear)
			rear_cmd_out <= c;
		else
			front_cmd_out <= c;
		@(posedge mclk_in);
		front_cmd_out <= '0;
		rear_cmd_out <= '0;
		#1 r = rear ? rear_rsp_in : front_rsp_in;
	endtask
	// master asks this unit to become its slave
	task init_slave(output logic ack);
		@(posedge mclk_in);
		ms_init_out <= 1'b1;
		@(posedge mclk_in);
		ms_init_out <= 1'b0;
		#1 ack = ms_init_ack_in;
	endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Purpose: self-checking bench for rcaw_top
// Assumes: 40 MHz clock, watchdog timeout register of 1, expiring after two ticks
// Notes:   power-down delays too long to run, only first steps checked
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic                mclk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out;
	logic [11:0]         paddr_in;
	logic [31:0]         pwdata_in, prdata_out, rd, w;
	logic                pslverr_out, button_in, mains_lost_in, link_ok_in, eth_timeout_in;
	logic                ms_init_in, dev_alarm_in, ms_init_ack_out, output_on_out, fans_on_out;
	logic                power_hold_out, save_out, power_fail_alarm_out, irq_out;
	logic                link_protection_alarm_out, error_led_out, err, ack, o;
	logic [2:0]          own;
	rcaw_pkg::rcaw_cmd_s front_cmd_in, rear_cmd_in, c;
	rcaw_pkg::rcaw_rsp_s front_rsp_out, rear_rsp_out;
	int                  failures, n_compared, seed, cyc, i, n;

	rcaw_top rcaw_top_inst (.mclk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .button_in, .mains_lost_in,
		.link_ok_in, .eth_timeout_in, .front_cmd_in, .rear_cmd_in, .ms_init_in, .dev_alarm_in,
		.front_rsp_out, .rear_rsp_out, .ms_init_ack_out, .output_on_out, .fans_on_out,
		.power_hold_out, .save_out, .power_fail_alarm_out, .link_protection_alarm_out,
		.error_led_out, .irq_out);
	rcaw_host_model host_inst (.mclk_in, .front_rsp_in(front_rsp_out), .rear_rsp_in(rear_rsp_out),
		.ms_init_ack_in(ms_init_ack_out), .front_cmd_out(front_cmd_in),
		.rear_cmd_out(rear_cmd_in), .ms_init_out(ms_init_in));

	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			failures++;
			finish_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task settle;
		repeat (2) @(posedge mclk_in);
		#1;
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	// expected answer from the owner held by the bench
	function automatic rcaw_pkg::rcaw_rsp_s f_rsp(input bit rear, input rcaw_pkg::rcaw_cmd_s k);
		logic bad;
		bad = (!rear && !k.sub_ok)
			|| (k.rem_req && own != rcaw_pkg::OWN_LOCAL
				&& own != (rear ? rcaw_pkg::OWN_REAR : rcaw_pkg::OWN_FRONT))
			|| (!rear && k.set_cmd && own != rcaw_pkg::OWN_LOCAL && own != rcaw_pkg::OWN_FRONT);
		return '{accept: !bad, error: bad};
	endfunction
	task cmd(input bit rear, input rcaw_pkg::rcaw_cmd_s k);
		rcaw_pkg::rcaw_rsp_s r;
		host_inst.send(rear, k, {$random(seed)} % 3, r);
		chk({30'h0, r}, {30'h0, f_rsp(rear, k)});
		if (r.accept && k.rem_req)
			own = rear ? rcaw_pkg::OWN_REAR : rcaw_pkg::OWN_FRONT;
		if (r.accept && k.rem_exit)
			own = rcaw_pkg::OWN_LOCAL;
	endtask
	task press;
		@(posedge mclk_in);
		button_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		button_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		#1;
	endtask
	task reset_dut;
		nrst_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
		nrst_in <= 1'b1;
		own = rcaw_pkg::OWN_LOCAL;
		#1;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{nrst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
		{button_in, mains_lost_in, eth_timeout_in, dev_alarm_in} = '0;
		{failures, n_compared, cyc} = '0;
		link_ok_in = 1'b1;
		seed = 56;
		reset_dut();
		chk(output_on_out, 1'b0);
		apb(1'b0, rcaw_pkg::OFS_WDTO, '0);
		chk(rd, rcaw_pkg::WDTO_RST);
		apb(1'b0, rcaw_pkg::OFS_CTRL, '0);
		chk(rd, rcaw_pkg::CTRL_RST);
		apb(1'b0, 12'h020, '0);
		chk({rd[30:0], err}, 32'h0000_0001);
		w = $random(seed) & 32'h7FFF_FFFF;
		apb(1'b1, rcaw_pkg::OFS_SETVAL, w);
		apb(1'b0, rcaw_pkg::OFS_SETVAL, '0);
		chk(rd, w);
		@(posedge mclk_in);
		dev_alarm_in <= 1'b1;
		@(posedge mclk_in);
		dev_alarm_in <= 1'b0;
		settle();
		chk(error_led_out, 1'b1);
		press();
		chk(error_led_out, 1'b0);
		o = output_on_out;
		press();
		chk(output_on_out, !o);
		for (i = 0; i < 8; i++) begin
			c = '0;
			c.msg = 1'b1;
			{c.sub_ok, c.scpi} = 2'($random(seed));
			cmd(i[0], c);
		end
		apb(1'b1, rcaw_pkg::OFS_IRQEN, 32'h0000_0004);
		c = '0;
		c.msg = 1'b1;
		c.sub_ok = 1'b1;
		c.rem_req = 1'b1;
		cmd(1'b1, c);
		cmd(1'b0, c);
		settle();
		chk(irq_out, 1'b1);
		apb(1'b0, rcaw_pkg::OFS_IRQST, '0);
		chk(rd, 32'h0000_0004);
		apb(1'b1, rcaw_pkg::OFS_IRQEN, '0);
		settle();
		chk(irq_out, 1'b0);
		apb(1'b1, rcaw_pkg::OFS_IRQCLR, 32'h0000_0004);
		apb(1'b0, rcaw_pkg::OFS_IRQST, '0);
		chk(rd, '0);
		c.rem_req = 1'b0;
		c.set_cmd = 1'b1;
		cmd(1'b0, c);
		c.set_cmd = 1'b0;
		c.out_on = 1'b1;
		cmd(1'b1, c);
		press();
		chk(output_on_out, 1'b1);
		host_inst.init_slave(ack);
		chk(ack, 1'b0);
		c.out_on = 1'b0;
		c.rem_exit = 1'b1;
		cmd(1'b1, c);
		host_inst.init_slave(ack);
		chk(ack, 1'b1);
		own = rcaw_pkg::OWN_MASTER;
		c.rem_exit = 1'b0;
		c.rem_req = 1'b1;
		cmd(1'b0, c);
		c.rem_req = 1'b0;
		cmd(1'b1, c);
		@(posedge mclk_in);
		link_ok_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		#1 chk(link_protection_alarm_out, 1'b1);
		@(posedge mclk_in);
		link_ok_in <= 1'b1;
		reset_dut();
		apb(1'b1, rcaw_pkg::OFS_WDTO, 32'h0000_0001);
		apb(1'b1, rcaw_pkg::OFS_CTRL, 32'h0000_0003);
		apb(1'b1, rcaw_pkg::OFS_IRQEN, 32'h0000_0001);
		c.rem_req = 1'b1;
		cmd(1'b1, c);
		c.rem_req = 1'b0;
		c.out_on = 1'b1;
		cmd(1'b1, c);
		eth_timeout_in <= 1'b1;
		n = 0;
		while (irq_out !== 1'b1 && n < 2 * rcaw_pkg::WDT_TICK_CYC + 100) begin
			@(posedge mclk_in);
			n++;
		end
		chk(irq_out, 1'b1);
		own = rcaw_pkg::OWN_LOCAL;
		apb(1'b0, rcaw_pkg::OFS_STATE, '0);
		chk({29'h0, rd[6:4]}, {29'h0, own});
		chk(output_on_out, 1'b1);
		c.out_on = 1'b0;
		c.set_cmd = 1'b1;
		cmd(1'b0, c);
		apb(1'b1, rcaw_pkg::OFS_SETVAL, w);
		@(posedge mclk_in);
		mains_lost_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		#1 chk({output_on_out, power_fail_alarm_out}, 32'h0000_0001);
		apb(1'b0, rcaw_pkg::OFS_SAVED, '0);
		chk(rd, {1'b1, w[30:0]});
		finish_test();
	end
endmodule
`default_nettype wire
